/* File: hw/gpls_top.sv */
// Pin latch set/clear/toggle command block with interrupt pin selectors, AXI4-Lite slave
`timescale 1ns/1ps
module gpls_top
  import gpls_pkg::*;
#(
  parameter int unsigned BP = B_PINS,
  parameter int unsigned CP = C_PINS
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [AXI_DW-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [A_PINS-1:0] port_a_pin_in,
  input  wire logic [BP-1:0]     port_b_pin_in,
  output logic      [BP-1:0]     port_b_out,
  output logic      [BP-1:0]     port_b_oe,
  output logic      [CP-1:0]     port_c_out,
  output logic      [CP-1:0]     port_c_oe,
  output logic      [NUM_XINT-1:0] external_interrupt_line,
  output logic                   external_nonmaskable_line
);

  // Read sequencer states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_MEM  = 2'b01,
    RD_RESP = 2'b10
  } gpls_rd_e;

  logic [AXI_AW-1:0]  aw_addr_q;     // Held write address
  logic               aw_full;       // Write address held
  logic [AXI_DW-1:0]  w_data_q;      // Held write data
  logic [3:0]         w_strb_q;      // Held write strobes
  logic               w_full;        // Write data held
  logic               wr_fire;       // Write performed this cycle
  gpls_reg_e          wr_id;         // Target of the write
  logic [AXI_DW-1:0]  wr_mask;       // Strobe mask of the write
  logic [AXI_DW-1:0]  wr_cmd;        // Command bits, unstrobed lanes forced to zero
  logic [BP-1:0]      cmd_b;         // Port B command bits
  logic [CP-1:0]      cmd_c;         // Port C command bits, reserved lanes dropped
  logic               wr_perm;       // Protected write permission
  logic               sel_we;        // Selector write enable
  gpls_rd_e           rd_state;      // Read sequencer state
  gpls_reg_e          rd_id;         // Target of the read in flight
  logic [SEL_AW-1:0]  sel_raddr;     // Selector read index
  logic [SEL_W-1:0]   sel_rdata;     // Selector read data
  logic [SEL_DEPTH*SEL_W-1:0] sel_flat; // All selectors
  logic [NUM_XINT-1:0] next_xint;    // Routed interrupt sources
  logic               next_nmi;      // Routed non-maskable source
  logic [SEL_W-1:0]   sel_nmi;       // Non-maskable selector

  // Write channel: address and data are captured independently, in any order
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_id   = gpls_decode(aw_addr_q);
  assign wr_mask = gpls_strb_mask(w_strb_q);
  assign wr_cmd  = w_data_q & wr_mask;
  assign cmd_b   = wr_cmd[BP-1:0];
  assign cmd_c   = wr_cmd[CP-1:0];

  // Write address holding register; ready drops while an address waits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full       <= 1'b0;
      aw_addr_q     <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full       <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_full       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
    else
      s_axi_awready <= !aw_full;
  end

  // Write data holding register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full       <= 1'b0;
      w_data_q     <= ZERO_WORD;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full       <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
    begin
      w_full       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else
      s_axi_wready <= !w_full;
  end

  // Write response; unmapped addresses answer SLVERR, read-only ones are silently kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Port B latch: only the toggle command reaches it here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port_b_out <= B_LATCH_RST;
    else if (wr_fire && wr_id == REG_B_TOG)
      // Output pins invert, non-output pins are cleared, zero bits keep
      port_b_out <= (port_b_out & ~(cmd_b & ~port_b_oe)) ^ (cmd_b & port_b_oe);
  end

  // Port C latch: set, clear and toggle commands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port_c_out <= C_LATCH_RST;
    else if (wr_fire)
    begin
      case (wr_id)
        REG_C_SET: port_c_out <= port_c_out | cmd_c;
        REG_C_CLR: port_c_out <= port_c_out & ~cmd_c;
        REG_C_TOG: port_c_out <= (port_c_out & ~(cmd_c & ~port_c_oe))
                                 ^ (cmd_c & port_c_oe);
        default:   port_c_out <= port_c_out;
      endcase
    end
  end

  // Pin direction: the enable is the output configuration itself, so a pin
  // that is not an output never carries its latch value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_b_oe <= B_DIR_RST;
      port_c_oe <= C_DIR_RST;
    end
    else if (wr_fire && wr_id == REG_B_DIR)
      port_b_oe <= (port_b_oe & ~wr_mask[BP-1:0]) | wr_cmd[BP-1:0];
    else if (wr_fire && wr_id == REG_C_DIR)
      port_c_oe <= (port_c_oe & ~wr_mask[CP-1:0]) | wr_cmd[CP-1:0];
  end

  // Protected write permission bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wr_perm <= 1'b0;
    else if (wr_fire && wr_id == REG_PERM && w_strb_q[0])
      wr_perm <= w_data_q[0];
  end

  // Selector writes land only while permission is open and lane 0 is strobed
  assign sel_we    = wr_fire && wr_id == REG_SEL && wr_perm && w_strb_q[0];
  assign sel_raddr = s_axi_araddr[SEL_IDX_LSB +: SEL_AW];

  gpls_sel_mem u_sel (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (sel_we),
    .waddr   (aw_addr_q[SEL_IDX_LSB +: SEL_AW]),
    .wdata   (w_data_q[SEL_W-1:0]),
    .raddr   (sel_raddr),
    .rdata   (sel_rdata),
    .flat    (sel_flat)
  );

  // Read sequencer; the extra state covers the selector store's read latency
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state      <= RD_IDLE;
      rd_id         <= REG_NONE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ZERO_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        RD_IDLE:
        begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready)
          begin
            rd_id         <= gpls_decode(s_axi_araddr);
            s_axi_arready <= 1'b0;
            rd_state      <= RD_MEM;
          end
        end
        RD_MEM:
        begin
          s_axi_rvalid <= 1'b1;
          s_axi_rresp  <= (rd_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
          case (rd_id)
            REG_B_DIR:  s_axi_rdata <= AXI_DW'(port_b_oe);
            REG_C_DIR:  s_axi_rdata <= AXI_DW'(port_c_oe);
            REG_B_DATA: s_axi_rdata <= AXI_DW'(port_b_out);
            REG_C_DATA: s_axi_rdata <= AXI_DW'(port_c_out);
            REG_PERM:   s_axi_rdata <= AXI_DW'(wr_perm);
            REG_SEL:    s_axi_rdata <= AXI_DW'(sel_rdata);
            default:    s_axi_rdata <= ZERO_WORD;
          endcase
          rd_state <= RD_RESP;
        end
        RD_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= RD_IDLE;
          end
        end
        default:
          rd_state <= RD_IDLE;
      endcase
    end
  end

  // Interrupt routing: lines 1-2 from the first port, the rest from the second
  for (genvar g = 0; g < NUM_XINT; g++)
  begin : g_xint
    if (g < XINT_A_NUM)
    begin : g_a
      assign next_xint[g] = port_a_pin_in[sel_flat[g*SEL_W +: SEL_W]];
    end
    else
    begin : g_b
      assign next_xint[g] = port_b_pin_in[sel_flat[g*SEL_W +: SEL_W]];
    end
  end
  assign sel_nmi  = sel_flat[NMI_IDX*SEL_W +: SEL_W];
  assign next_nmi = port_a_pin_in[sel_nmi];

  // Registered routed sources, one cycle behind the pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      external_interrupt_line   <= '0;
      external_nonmaskable_line <= 1'b0;
    end
    else
    begin
      external_interrupt_line   <= next_xint;
      external_nonmaskable_line <= next_nmi;
    end
  end

  // Checks of the latch commands, read-back and routing
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_cset_forces_high: assert property (
    wr_fire && wr_id == REG_C_SET |=> (port_c_out & $past(cmd_c)) == $past(cmd_c))
    else $error("set command left a latch low");

  a_cclr_forces_low: assert property (
    wr_fire && wr_id == REG_C_CLR |=> (port_c_out & $past(cmd_c)) == '0)
    else $error("clear command left a latch high");

  a_zero_keeps_latch: assert property (
    wr_fire && (wr_id == REG_C_SET || wr_id == REG_C_CLR || wr_id == REG_C_TOG)
    |=> ((port_c_out ^ $past(port_c_out)) & ~$past(cmd_c)) == '0)
    else $error("zero command bit changed a latch");

  a_btog_inverts: assert property (
    wr_fire && wr_id == REG_B_TOG
    |=> ((port_b_out ^ $past(port_b_out)) & $past(cmd_b & port_b_oe))
        == $past(cmd_b & port_b_oe))
    else $error("toggle did not invert an output pin");

  a_tog_nonout_clear: assert property (
    wr_fire && wr_id == REG_C_TOG |=> (port_c_out & $past(cmd_c & ~port_c_oe)) == '0)
    else $error("toggle on non-output pin did not clear latch");

  a_set_stays_undriven: assert property (
    wr_fire && wr_id == REG_C_SET |=> (port_c_oe & $past(cmd_c & ~port_c_oe)) == '0)
    else $error("set command enabled a non-output pin");

  a_cmd_reads_zero: assert property (
    s_axi_rvalid && (rd_id == REG_B_TOG || rd_id == REG_C_SET || rd_id == REG_C_CLR
                     || rd_id == REG_C_TOG) |-> s_axi_rdata == ZERO_WORD)
    else $error("command register read nonzero");

  a_sel_locked: assert property (
    wr_fire && wr_id == REG_SEL && !wr_perm |=> $stable(sel_flat))
    else $error("selector written without permission");

  a_sel_upper_zero: assert property (
    s_axi_rvalid && rd_id == REG_SEL |-> s_axi_rdata[AXI_DW-1:SEL_W] == '0)
    else $error("selector reserved bits read nonzero");

  a_nmi_follows_pin: assert property (
    ##1 external_nonmaskable_line == $past(port_a_pin_in[sel_nmi]))
    else $error("non-maskable line does not follow selected pin");

  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer not two cycles after address");

endmodule

/* File: hw/gpls_pkg.sv */
// Shared constants, register map and decode helpers for the latch command block
package gpls_pkg;

  localparam int unsigned AXI_AW     = 12;    // Byte address width of the slave
  localparam int unsigned AXI_DW     = 32;    // Data width
  localparam int unsigned B_PINS     = 32;    // Second port pin count
  localparam int unsigned C_PINS     = 24;    // Third port pin count
  localparam int unsigned A_PINS     = 32;    // First port pin count (selector source)
  localparam int unsigned SEL_W      = 5;     // Selector field width
  localparam int unsigned SEL_REG_W  = 16;    // Selector register width
  localparam int unsigned SEL_DEPTH  = 8;     // Seven interrupt lines plus the non-maskable one
  localparam int unsigned SEL_AW     = 3;     // Selector index width
  localparam int unsigned NUM_XINT   = 7;     // External interrupt lines
  localparam int unsigned XINT_A_NUM = 2;     // Lines 1 and 2 pick from the first port
  localparam int unsigned NMI_IDX    = 7;     // Selector slot of the non-maskable line
  localparam int unsigned SEL_IDX_LSB = 2;    // Word index position in the byte address

  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_B_TOG  = 12'h000;
  localparam logic [AXI_AW-1:0] OFS_C_SET  = 12'h004;
  localparam logic [AXI_AW-1:0] OFS_C_CLR  = 12'h008;
  localparam logic [AXI_AW-1:0] OFS_C_TOG  = 12'h00C;
  localparam logic [AXI_AW-1:0] OFS_B_DIR  = 12'h020;
  localparam logic [AXI_AW-1:0] OFS_C_DIR  = 12'h024;
  localparam logic [AXI_AW-1:0] OFS_B_DATA = 12'h028;
  localparam logic [AXI_AW-1:0] OFS_C_DATA = 12'h02C;
  localparam logic [AXI_AW-1:0] OFS_PERM   = 12'h030;
  localparam logic [AXI_AW-1:0] OFS_SEL    = 12'h040;  // Eight words, 0x040..0x05C
  localparam logic [AXI_AW-1:0] SEL_SPAN_MASK = 12'hFE0;

  // Reset values
  localparam logic [B_PINS-1:0]  B_LATCH_RST = 32'h0000_0000;
  localparam logic [C_PINS-1:0]  C_LATCH_RST = 24'h00_0000;
  localparam logic [B_PINS-1:0]  B_DIR_RST   = 32'h0000_0000;
  localparam logic [C_PINS-1:0]  C_DIR_RST   = 24'h00_0000;
  localparam logic [SEL_W-1:0]   SEL_RST     = 5'h00;
  localparam logic [AXI_DW-1:0]  ZERO_WORD   = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded register identity
  typedef enum logic [3:0] {
    REG_B_TOG  = 4'h0,
    REG_C_SET  = 4'h1,
    REG_C_CLR  = 4'h2,
    REG_C_TOG  = 4'h3,
    REG_B_DIR  = 4'h4,
    REG_C_DIR  = 4'h5,
    REG_B_DATA = 4'h6,
    REG_C_DATA = 4'h7,
    REG_PERM   = 4'h8,
    REG_SEL    = 4'h9,
    REG_NONE   = 4'hF
  } gpls_reg_e;

  // Address to register identity, shared by the read and write paths
  function automatic gpls_reg_e gpls_decode(input logic [AXI_AW-1:0] addr);
    gpls_reg_e id;
    id = REG_NONE;
    case (addr)
      OFS_B_TOG:  id = REG_B_TOG;
      OFS_C_SET:  id = REG_C_SET;
      OFS_C_CLR:  id = REG_C_CLR;
      OFS_C_TOG:  id = REG_C_TOG;
      OFS_B_DIR:  id = REG_B_DIR;
      OFS_C_DIR:  id = REG_C_DIR;
      OFS_B_DATA: id = REG_B_DATA;
      OFS_C_DATA: id = REG_C_DATA;
      OFS_PERM:   id = REG_PERM;
      default:    id = REG_NONE;
    endcase
    if ((addr & SEL_SPAN_MASK) == OFS_SEL && addr[1:0] == 2'h0)
      id = REG_SEL;
    return id;
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [AXI_DW-1:0] gpls_strb_mask(input logic [3:0] strb);
    logic [AXI_DW-1:0] m;
    m = ZERO_WORD;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{strb[i]}};
    return m;
  endfunction

endpackage

/* File: hw/gpls_sel_mem.sv */
// Selector store: eight 5-bit words, registered read port and a flat view
`timescale 1ns/1ps
module gpls_sel_mem
  import gpls_pkg::*;
#(
  parameter int unsigned DEPTH = SEL_DEPTH,
  parameter int unsigned WIDTH = SEL_W,
  parameter int unsigned AW    = SEL_AW
)(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   we,
  input  wire logic [AW-1:0]          waddr,
  input  wire logic [WIDTH-1:0]       wdata,
  input  wire logic [AW-1:0]          raddr,
  output logic      [WIDTH-1:0]       rdata,
  output logic      [DEPTH*WIDTH-1:0] flat
);

  logic [WIDTH-1:0] mem [DEPTH];   // Selector words

  // Storage; every word resets so interrupt routing is defined at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= SEL_RST;
    end
    else if (we)
      mem[waddr] <= wdata;
  end

  // Registered read data, one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rdata <= SEL_RST;
    else
      rdata <= mem[raddr];
  end

  // Flat view for the routing logic, which needs all words at once
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_flat
    assign flat[g*WIDTH +: WIDTH] = mem[g];
  end

endmodule

/* File: dv/gpls_pin_loads.sv */
// Pin-side model: external loads on the second, third and first ports
`timescale 1ns/1ps
module gpls_pin_loads
  import gpls_pkg::*;
(
  input  wire logic [B_PINS-1:0] port_b_out,
  input  wire logic [B_PINS-1:0] port_b_oe,
  input  wire logic [C_PINS-1:0] port_c_out,
  input  wire logic [C_PINS-1:0] port_c_oe,
  input  wire logic [B_PINS-1:0] ext_b,
  input  wire logic [A_PINS-1:0] ext_a,
  output logic      [B_PINS-1:0] port_b_pin_in,
  output logic      [C_PINS-1:0] port_c_pin,
  output logic      [A_PINS-1:0] port_a_pin_in
);
  // Second port: a driven pin follows its latch, else the outside source wins
  assign port_b_pin_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
  // Third port: weak pull-down, so an undriven pin reads low whatever its latch holds
  assign port_c_pin    = port_c_oe & port_c_out;
  // First port is input only here, fed straight from the outside source
  assign port_a_pin_in = ext_a;
endmodule

/* File: dv/gpls_top_tb_top.sv */
// Self-checking bench for the pin latch command block
`timescale 1ns/1ps
module gpls_top_tb_top
  import gpls_pkg::*;
;
  logic              aclk          = 1'b0;  // 100 MHz system clock
  logic              aresetn       = 1'b0;  // Synchronous, active low
  logic [AXI_AW-1:0] s_axi_awaddr  = '0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_awready;
  logic [AXI_DW-1:0] s_axi_wdata   = '0;
  logic [3:0]        s_axi_wstrb   = 4'h0;
  logic              s_axi_wvalid  = 1'b0;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready  = 1'b0;
  logic [AXI_AW-1:0] s_axi_araddr  = '0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_arready;
  logic [AXI_DW-1:0] s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready  = 1'b0;
  logic [A_PINS-1:0] port_a_pin_in;
  logic [B_PINS-1:0] port_b_pin_in;
  logic [B_PINS-1:0] port_b_out;
  logic [B_PINS-1:0] port_b_oe;
  logic [C_PINS-1:0] port_c_out;
  logic [C_PINS-1:0] port_c_oe;
  logic [C_PINS-1:0] port_c_pin;       // Resolved third-port pin level
  logic [NUM_XINT-1:0] external_interrupt_line;
  logic              external_nonmaskable_line;
  logic [B_PINS-1:0] ext_b         = '0;  // Outside source on second-port pins
  logic [A_PINS-1:0] ext_a         = '0;  // Outside source on first-port pins
  logic [AXI_DW-1:0] rd;               // Last read data
  logic [1:0]        rs;               // Last read response
  logic [1:0]        ws;               // Last write response
  int                err_count       = 0;
  int                samples_checked = 0;

  // Free-running clock, 10 ns period
  always #5 aclk = ~aclk;

  gpls_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port_a_pin_in(port_a_pin_in),
    .port_b_pin_in(port_b_pin_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
    .port_c_out(port_c_out), .port_c_oe(port_c_oe),
    .external_interrupt_line(external_interrupt_line),
    .external_nonmaskable_line(external_nonmaskable_line)
  );

  gpls_pin_loads loads (
    .port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_c_out(port_c_out),
    .port_c_oe(port_c_oe), .ext_b(ext_b), .ext_a(ext_a),
    .port_b_pin_in(port_b_pin_in), .port_c_pin(port_c_pin), .port_a_pin_in(port_a_pin_in)
  );

  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Single comparison point; x or z never counts as a match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A handshake that never completes ends the run instead of hanging
  task automatic limit(input int n);
    if (n >= 200)
    begin
      err_count++;
      end_of_test();
    end
  endtask

  // Write one full word; address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      limit(n);
    end while (!s_axi_bvalid);
    ws = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read one word; rready is held from the start until rvalid is seen
  task automatic axi_rd(input logic [AXI_AW-1:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      limit(n);
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Reset state: latches low, pins undriven, selectors cleared
  task automatic test_reset();
    check(port_b_out, 32'h0000_0000);
    check({8'h00, port_c_out}, 32'h0000_0000);
    check(port_b_oe, 32'h0000_0000);
    check({8'h00, port_c_oe}, 32'h0000_0000);
    for (int k = 0; k < 8; k++)
    begin
      axi_rd(OFS_SEL + 12'(4 * k));
      check(rd, 32'h0000_0000);
    end
    $display("test_reset done");
  endtask

  // Third port: set, clear, toggle on a mix of output and non-output pins
  task automatic test_port_c();
    axi_wr(OFS_C_DIR, 32'h00FF_00FF);
    axi_wr(OFS_C_SET, 32'hFF00_F0F0);
    axi_rd(OFS_C_DATA);
    check(rd, 32'h0000_F0F0);
    check({8'h00, port_c_out}, 32'h0000_F0F0);
    check({8'h00, port_c_pin}, 32'h0000_00F0);
    check({8'h00, port_c_oe}, 32'h00FF_00FF);
    axi_rd(OFS_C_SET);
    check(rd, 32'h0000_0000);
    axi_rd(OFS_C_CLR);
    check(rd, 32'h0000_0000);
    axi_rd(OFS_C_TOG);
    check(rd, 32'h0000_0000);
    axi_wr(OFS_C_CLR, 32'h0000_0000);
    axi_wr(OFS_C_SET, 32'h0000_0000);
    axi_wr(OFS_C_TOG, 32'h0000_0000);
    axi_rd(OFS_C_DATA);
    check(rd, 32'h0000_F0F0);
    axi_wr(OFS_C_CLR, 32'h0000_0030);
    check({8'h00, port_c_out}, 32'h0000_F0C0);
    check({8'h00, port_c_pin}, 32'h0000_00C0);
    // Outputs 0, 7, 23 invert; non-outputs 12, 15 are cleared
    axi_wr(OFS_C_TOG, 32'hFF80_9081);
    axi_rd(OFS_C_DATA);
    check(rd, 32'h0080_6041);
    check({8'h00, port_c_pin}, 32'h0080_0041);
    check({8'h00, port_c_out & ~port_c_oe}, 32'h0000_6000);
    check(ws, {30'h0, RESP_OKAY});
    $display("test_port_c done");
  endtask

  // Second port: walking toggle on each pin, then a split-direction toggle
  task automatic test_port_b();
    logic [31:0] exp;
    exp = 32'h0000_0000;
    axi_wr(OFS_B_DIR, 32'hFFFF_FFFF);
    for (int i = 0; i < 32; i++)
    begin
      axi_wr(OFS_B_TOG, 32'h1 << i);
      exp = exp | (32'h1 << i);
      check(port_b_out, exp);
    end
    axi_rd(OFS_B_TOG);
    check(rd, 32'h0000_0000);
    axi_wr(OFS_B_DIR, 32'h0000_FFFF);
    axi_wr(OFS_B_TOG, 32'h0F0F_0F0F);
    axi_rd(OFS_B_DATA);
    check(rd, 32'hF0F0_F0F0);
    check(port_b_pin_in & port_b_oe, 32'h0000_F0F0);
    $display("test_port_b done");
  endtask

  // Selectors: protection, field width, and pin choice for every line
  task automatic test_selector();
    axi_wr(OFS_SEL, 32'h0000_001F);
    axi_rd(OFS_SEL);
    check(rd, 32'h0000_0000);
    axi_wr(OFS_PERM, 32'h0000_0001);
    axi_rd(OFS_PERM);
    check(rd, 32'h0000_0001);
    axi_wr(OFS_B_DIR, 32'h0000_0000);
    for (int k = 0; k < 8; k++)
    begin
      axi_wr(OFS_SEL + 12'(4 * k), 32'hFFFF_FFE0 | 32'(31 - k));
      axi_rd(OFS_SEL + 12'(4 * k));
      check(rd, 32'(31 - k));
    end
    // Lines 1, 2 and the non-maskable one pick pins 31, 30, 24 of the first port
    @(posedge aclk);
    ext_a <= 32'h8100_0000;
    ext_b <= 32'h2A00_0000;
    repeat (3) @(posedge aclk);
    check({25'h0, external_interrupt_line}, 32'h0000_0055);
    check({31'h0, external_nonmaskable_line}, 32'h0000_0001);
    ext_a <= 32'h7EFF_FFFF;
    ext_b <= 32'hD5FF_FFFF;
    repeat (3) @(posedge aclk);
    check({25'h0, external_interrupt_line}, 32'h0000_002A);
    check({31'h0, external_nonmaskable_line}, 32'h0000_0000);
    // Closing the permission again must lock the non-maskable selector at 24
    axi_wr(OFS_PERM, 32'h0000_0000);
    axi_wr(OFS_SEL + 12'h01C, 32'h0000_0003);
    axi_rd(OFS_SEL + 12'h01C);
    check(rd, 32'h0000_0018);
    $display("test_selector done");
  endtask

  // Unmapped places answer with an error response
  task automatic test_unmapped();
    axi_rd(12'h010);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_wr(12'h100, 32'hFFFF_FFFF);
    check({30'h0, ws}, {30'h0, RESP_SLVERR});
    $display("test_unmapped done");
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset();
    test_port_c();
    test_port_b();
    test_selector();
    test_unmapped();
    end_of_test();
  end

  // Watchdog: the whole sequence needs well under 10,000 cycles
  initial
  begin
    #500000;
    err_count++;
    end_of_test();
  end
endmodule
